// ### rtl/wdsm_top.sv
// Watchdog system monitor: protected control register, counter and reset request.
// Assumes a register port on CLK; POR and other resets come from the reset controller.
`timescale 1ns/1ps
`default_nettype none
`include "wdsm_params.svh"
module wdsm_top
	import wdsm_pkg::*;
(
	input  wire logic       CLK,         // 200 MHz system clock.
	input  wire logic       RESET,       // Synchronous reset, any source.
	input  wire logic       POR,         // Power-on reset, synchronous, high.
	input  wire logic       WDT_RESET,   // High when current reset came from this block.
	input  wire logic       LOW_POWER,   // Processor in idle or power-down, async level.
	input  wire logic [3:0] ADDR,        // Register address.
	input  wire logic [7:0] WDATA,       // Write data.
	input  wire logic       WR,          // Write strobe.
	input  wire logic       RD,          // Read strobe.
	output logic      [7:0] RDATA,       // Read data, valid the cycle after RD.
	output logic            SYS_RESET,   // Reset request to the reset controller.
	output logic            RUN_ENABLE   // Current run enable state.
);
	wdsm_tick_if tif ();

	logic        lp_m_q, lp_s_q, lp_prev_q;
	logic        run_q, run_d;
	logic        lp_run_q, lp_run_d;
	logic        flag_q, flag_d;
	logic [2:0]  sel_q, sel_d;
	wdsm_byte_t  boot_q, boot_d;
	logic [6:0]  cnt_q, cnt_d;
	logic        clr_q, clr_d;
	logic        sysrst_q, sysrst_d;
	wdsm_byte_t  rdata_q, rdata_d;
	wdsm_ta_state_t ta_q, ta_d;
	logic [2:0]  ta_cnt_q, ta_cnt_d;
	logic        ctl_wr, ta_wr, lp_edge, counting;

	wdsm_prescaler u_pre (
		.clk (CLK),
		.rst (RESET),
		.tif (tif)
	);

	// Low-power state comes from another domain, so it is synchronised first.
	always_ff @(posedge CLK) begin
		if (RESET) begin
			lp_m_q <= 1'b0;
			lp_s_q <= 1'b0;
			lp_prev_q <= 1'b0;
		end else begin
			lp_m_q <= LOW_POWER;
			lp_s_q <= lp_m_q;
			lp_prev_q <= lp_s_q;
		end
	end

	// Timed access: two key writes to the control offset open a short window.
	always_comb begin
		ta_d = ta_q;
		ta_cnt_d = ta_cnt_q;
		ctl_wr = WR && (ADDR == `WDSM_OFF_CONTROL);
		ta_wr = 1'b0;
		case (ta_q)
			WDSM_TA_IDLE: begin
				if (ctl_wr && WDATA == `WDSM_TA_KEY1) begin
					ta_d = WDSM_TA_HALF;
				end
			end
			WDSM_TA_HALF: begin
				if (ctl_wr && WDATA == `WDSM_TA_KEY2) begin
					ta_d = WDSM_TA_OPEN;
					ta_cnt_d = `WDSM_TA_WINDOW;
				end else if (WR) begin
					ta_d = WDSM_TA_IDLE;
				end
			end
			WDSM_TA_OPEN: begin
				ta_cnt_d = ta_cnt_q - 3'h1;
				if (ctl_wr) begin
					ta_wr = 1'b1;
					ta_d = WDSM_TA_IDLE;
				end else if (ta_cnt_q == 3'h0) begin
					ta_d = WDSM_TA_IDLE;
				end
			end
			default: ta_d = WDSM_TA_IDLE;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			ta_q <= WDSM_TA_IDLE;
			ta_cnt_q <= 3'h0;
		end else begin
			ta_q <= ta_d;
			ta_cnt_q <= ta_cnt_d;
		end
	end

	// Control register, reset flag and boot byte.
	always_comb begin
		run_d = run_q;
		lp_run_d = lp_run_q;
		sel_d = sel_q;
		flag_d = flag_q;
		boot_d = boot_q;
		clr_d = 1'b0;
		if (ta_wr) begin
			run_d = WDATA[`WDSM_BIT_RUN_EN];
			lp_run_d = WDATA[`WDSM_BIT_LP_RUN];
			sel_d = WDATA[2:0];
			flag_d = WDATA[`WDSM_BIT_RST_FLAG];
			clr_d = WDATA[`WDSM_BIT_CLR_STROBE];
		end
		if (WR && ADDR == `WDSM_OFF_BOOTCFG) begin
			boot_d = WDATA;
		end
	end

	always_ff @(posedge CLK) begin
		if (POR) begin
			lp_run_q <= 1'b0;
			sel_q <= 3'h0;
			flag_q <= 1'b0;
			boot_q <= `WDSM_BOOT_UNPROG;
		end else if (RESET) begin
			flag_q <= flag_q | WDT_RESET;
		end else begin
			lp_run_q <= lp_run_d;
			sel_q <= sel_d;
			flag_q <= flag_d;
			boot_q <= boot_d;
		end
	end

	// Every reset other than power-on reloads run enable from the boot byte; power-on clears run
	// enable and restores that byte to its unprogrammed value, which keeps the watchdog disabled.
	always_ff @(posedge CLK) begin
		if (RESET) begin
			run_q <= !POR && !boot_q[`WDSM_BIT_BOOT_DIS];
			clr_q <= 1'b0;
		end else begin
			run_q <= run_d;
			clr_q <= clr_d;
		end
	end

	// Counter of prescaled ticks; clears on strobe and low-power transitions.
	always_comb begin
		lp_edge = lp_s_q ^ lp_prev_q;
		counting = run_q && (!lp_s_q || lp_run_q);
		cnt_d = cnt_q;
		sysrst_d = 1'b0;
		if (clr_q || lp_edge || !run_q) begin
			cnt_d = 7'h00;
		end else if (counting && tif.tick) begin
			if (cnt_q == `WDSM_TIMEOUT_TICKS - 7'h01) begin
				cnt_d = 7'h00;
				sysrst_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 7'h01;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			cnt_q <= 7'h00;
			sysrst_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			sysrst_q <= sysrst_d;
		end
	end

	assign tif.clr = clr_q || lp_edge;
	assign tif.run = counting;
	assign tif.sel = sel_q;

	// Read mux; clear strobe and reserved bit read zero.
	always_comb begin
		rdata_d = 8'h00;
		if (RD) begin
			case (ADDR)
				`WDSM_OFF_CONTROL: rdata_d = {run_q, 1'b0, 1'b0, lp_run_q,
					flag_q, sel_q};
				`WDSM_OFF_BOOTCFG: rdata_d = boot_q;
				`WDSM_OFF_COUNT:   rdata_d = {1'b0, cnt_q};
				default:           rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			rdata_q <= 8'h00;
			RUN_ENABLE <= 1'b0;
			SYS_RESET <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			RUN_ENABLE <= run_q;
			SYS_RESET <= sysrst_q;
		end
	end
	assign RDATA = rdata_q;
endmodule
`default_nettype wire

// ### rtl/wdsm_params.svh
// Constants for the watchdog system monitor: register offsets, field positions,
// reset values and timing counts. Assumes inclusion by bare name.
`ifndef WDSM_PARAMS_SVH
`define WDSM_PARAMS_SVH

`define WDSM_ADDR_W          4
`define WDSM_OFF_CONTROL     4'h0
`define WDSM_OFF_BOOTCFG     4'h4
`define WDSM_OFF_COUNT       4'h8
`define WDSM_BIT_RUN_EN      7
`define WDSM_BIT_CLR_STROBE  6
`define WDSM_BIT_LP_RUN      4
`define WDSM_BIT_RST_FLAG    3
`define WDSM_BOOT_UNPROG     8'hff
`define WDSM_BIT_BOOT_DIS    7
`define WDSM_TIMEOUT_TICKS   7'h40
`define WDSM_LOSC_HZ         10000
`define WDSM_CLK_HZ          200000000
`define WDSM_LOSC_DIV        (`WDSM_CLK_HZ / `WDSM_LOSC_HZ)
`define WDSM_TA_KEY1         8'haa
`define WDSM_TA_KEY2         8'h55
`define WDSM_TA_WINDOW       3'h4

`endif

// ### rtl/wdsm_pkg.sv
// Types shared by the watchdog system monitor modules.
// Assumes wdsm_params.svh is compiled alongside.
package wdsm_pkg;
	typedef enum logic [1:0] {
		WDSM_TA_IDLE  = 2'b00,
		WDSM_TA_HALF  = 2'b01,
		WDSM_TA_OPEN  = 2'b10
	} wdsm_ta_state_t;
	typedef logic [7:0] wdsm_byte_t;
endpackage

// ### rtl/wdsm_tick_if.sv
// Interface carrying prescaler ticks and controls between the watchdog modules.
// Assumes a single clock domain.
`timescale 1ns/1ps
`default_nettype none
interface wdsm_tick_if;
	logic       clr;
	logic       run;
	logic [2:0] sel;
	logic       tick;
	modport pre (input clr, input run, input sel, output tick);
	modport top (output clr, output run, output sel, input tick);
endinterface
`default_nettype wire

// ### rtl/wdsm_prescaler.sv
// Low-speed oscillator emulation and selectable divider chain for the watchdog.
// Assumes one clock; emits one-cycle tick pulses at the prescaled rate.
`timescale 1ns/1ps
`default_nettype none
`include "wdsm_params.svh"
module wdsm_prescaler
	import wdsm_pkg::*;
(
	input  wire logic  clk,   // System clock.
	input  wire logic  rst,   // Synchronous reset.
	wdsm_tick_if.pre   tif    // Control in, tick out.
);
	localparam int DIV_CYCLES = `WDSM_LOSC_DIV;
	logic [15:0] osc_cnt_q, osc_cnt_d;
	logic [7:0]  chain_q, chain_d;
	logic        tick_q, tick_d;
	logic        osc_tick;
	logic [7:0]  scale_mask;

	always_comb begin
		case (tif.sel)
			3'h0: scale_mask = 8'h00;
			3'h1: scale_mask = 8'h01;
			3'h2: scale_mask = 8'h07;
			3'h3: scale_mask = 8'h0f;
			3'h4: scale_mask = 8'h1f;
			3'h5: scale_mask = 8'h3f;
			3'h6: scale_mask = 8'h7f;
			default: scale_mask = 8'hff;
		endcase
	end

	// The chain divides the low-speed clock; the selected scale picks the tap.
	always_comb begin
		osc_tick = (osc_cnt_q == 16'(DIV_CYCLES - 1));
		osc_cnt_d = osc_tick ? 16'h0000 : osc_cnt_q + 16'h0001;
		chain_d = chain_q;
		tick_d = 1'b0;
		if (tif.clr || !tif.run) begin
			chain_d = 8'h00;
		end else if (osc_tick) begin
			chain_d = chain_q + 8'h01;
			tick_d = ((chain_q & scale_mask) == scale_mask);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			osc_cnt_q <= 16'h0000;
			chain_q <= 8'h00;
			tick_q <= 1'b0;
		end else begin
			osc_cnt_q <= osc_cnt_d;
			chain_q <= chain_d;
			tick_q <= tick_d;
		end
	end
	assign tif.tick = tick_q;
endmodule
`default_nettype wire

// ### sim/wdsm_top_sva_sva.sv
// Assertions on the watchdog system monitor ports.
// Assumes a bind to wdsm_top; each input mirrors a top port.
`timescale 1ns/1ps
`default_nettype none
module wdsm_top_sva (
	input wire logic       CLK,        // Clock.
	input wire logic       RESET,      // Reset.
	input wire logic       POR,        // Power-on.
	input wire logic       WDT_RESET,  // Cause.
	input wire logic       LOW_POWER,  // Sleep.
	input wire logic [3:0] ADDR,       // Address.
	input wire logic [7:0] WDATA,      // Data in.
	input wire logic       WR,         // Write.
	input wire logic       RD,         // Read.
	input wire logic [7:0] RDATA,      // Data out.
	input wire logic       SYS_RESET,  // Request.
	input wire logic       RUN_ENABLE  // Running.
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);
	chk_rdata_quiet: assert property (!RD |=> RDATA == 8'h00)
		else $error("read data outside a read");
	chk_res_zero: assert property (RD && ADDR == 4'h0 |=> RDATA[6:5] == 2'b00)
		else $error("bits six or five read as one");
	chk_req_pulse: assert property (SYS_RESET |=> !SYS_RESET)
		else $error("long reset request");
	chk_req_run: assert property (SYS_RESET |-> $past(RUN_ENABLE))
		else $error("request while stopped");
	chk_quiet_reset: assert property (disable iff (1'b0) RESET |=> RDATA == 8'h00 && !SYS_RESET)
		else $error("outputs active in reset");
	chk_run_write: assert property ($changed(RUN_ENABLE) |->
		$past(WR && ADDR == 4'h0, 2) && $past(WDATA[7], 2) == RUN_ENABLE
		|| $past(RESET) || $past(RESET, 2) || $past(RESET, 3))
		else $error("run enable changed without write");
	chk_boot_por: assert property (disable iff (1'b0)
		POR ##1 (!RESET && !WR) [*2] ##1 RD && ADDR == 4'h4 |=> RDATA == 8'hff)
		else $error("boot byte wrong after power-on");
	chk_clear_zero: assert property (
		WR && ADDR == 4'h0 && WDATA == 8'h55 ##1 WR && ADDR == 4'h0 && WDATA[6]
		##[2:3] RD && ADDR == 4'h8 |=> RDATA == 8'h00)
		else $error("count not zero after clear");
endmodule
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the watchdog system monitor top level.
// Assumes the rtl files and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "wdsm_params.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
	$display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
	import wdsm_pkg::*;
	logic       CLK = 1'b0, RESET = 1'b1, POR = 1'b1, WDT_RESET = 1'b0;
	logic       LOW_POWER = 1'b0, WR = 1'b0, RD = 1'b0, SYS_RESET, RUN_ENABLE;
	logic [3:0] ADDR = 4'h0;
	wdsm_byte_t WDATA = 8'h00, RDATA, r;
	int         n_fail = 0, comparisons = 0, cyc = 0;
	wdsm_byte_t wv [4] = '{8'h00, 8'h95, 8'hff, 8'h2a};
	wdsm_byte_t ev [4] = '{8'h00, 8'h95, 8'h9f, 8'h0a};
	always #2.5 CLK = ~CLK;
	wdsm_top DUT (.CLK, .RESET, .POR, .WDT_RESET, .LOW_POWER, .ADDR, .WDATA, .WR, .RD,
		.RDATA, .SYS_RESET, .RUN_ENABLE);
	task automatic bus(input logic w, input logic rr, input logic [3:0] a, input wdsm_byte_t d);
		WR <= w;
		RD <= rr;
		ADDR <= a;
		WDATA <= d;
		@(posedge CLK);
	endtask
	task automatic idle(input int n);
		repeat (n) bus(1'b0, 1'b0, 4'h0, 8'h00);
	endtask
	task automatic rd(input logic [3:0] a);
		idle(1);
		bus(1'b0, 1'b1, a, 8'h00);
		RD <= 1'b0;
		@(negedge CLK);
		r = RDATA;
		@(posedge CLK);
	endtask
	task automatic ta_wr(input wdsm_byte_t d);
		bus(1'b1, 1'b0, 4'h0, `WDSM_TA_KEY1);
		bus(1'b1, 1'b0, 4'h0, `WDSM_TA_KEY2);
		bus(1'b1, 1'b0, 4'h0, d);
	endtask
	task automatic rst(input logic p, input logic w);
		RESET <= 1'b1;
		POR <= p;
		WDT_RESET <= w;
		repeat (10) @(posedge CLK);
		RESET <= 1'b0;
		POR <= 1'b0;
		WDT_RESET <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic print_verdict();
		if (n_fail == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_fail++;
			print_verdict();
		end
	end
	initial begin
		rst(1'b1, 1'b0);
		rd(4'h4);
		`CHK(r, `WDSM_BOOT_UNPROG)
		for (int i = 0; i < 4; i++) begin
			ta_wr(wv[i]);
			rd(4'h0);
			`CHK(r, ev[i])
			`CHK(RUN_ENABLE, ev[i][7])
		end
		idle(4);
		bus(1'b1, 1'b0, 4'h0, 8'h97);
		bus(1'b1, 1'b0, 4'h0, `WDSM_TA_KEY1);
		bus(1'b1, 1'b0, 4'h0, 8'h97);
		rd(4'h0);
		`CHK(r, 8'h0a)
		ta_wr(8'h40);
		idle(20500);
		rd(4'h8);
		`CHK(r, 8'h00)
		ta_wr(8'hc0);
		idle(20500);
		rd(4'h8);
		`CHK(r != 8'h00, 1'b1)
		`CHK(SYS_RESET, 1'b0)
		ta_wr(8'hc0);
		rd(4'h8);
		`CHK(r, 8'h00)
		idle(20500);
		rd(4'h8);
		`CHK(r != 8'h00, 1'b1)
		LOW_POWER <= 1'b1;
		idle(4);
		rd(4'h8);
		`CHK(r, 8'h00)
		idle(20500);
		rd(4'h8);
		`CHK(r, 8'h00)
		LOW_POWER <= 1'b0;
		ta_wr(8'h15);
		bus(1'b1, 1'b0, 4'h4, 8'h7f);
		idle(1);
		rst(1'b0, 1'b1);
		rd(4'h0);
		`CHK(r[7], 1'b1)
		`CHK(r[3], 1'b1)
		`CHK({r[4], r[2:0]}, 4'hd)
		rst(1'b0, 1'b0);
		rd(4'h0);
		`CHK(r[3], 1'b1)
		rst(1'b1, 1'b0);
		rd(4'h4);
		`CHK(r, 8'hff)
		rd(4'h0);
		`CHK(r, 8'h00)
		print_verdict();
	end
endmodule
bind wdsm_top wdsm_top_sva u_sva (.CLK, .RESET, .POR, .WDT_RESET, .LOW_POWER, .ADDR, .WDATA,
	.WR, .RD, .RDATA, .SYS_RESET, .RUN_ENABLE);
`default_nettype wire
